// [dv/nsw_ctrl_chk.sv]
// nsw_ctrl_chk.sv: port assertions for the self-write control unit.
// assumes: bound to nsw_ctrl; one clock, async active-low reset.
`timescale 1ns/1ps
`include "nsw_consts.vh"

module nsw_chk
#(
   parameter PROG_CYCLES = 8
)
(
   // clock and reset
   input wire SYS_CLK,
   input wire RST_B,
   input wire WARM_RST,
   // register port
   input wire [`NSW_SEL_W-1:0] SFR_SEL,
   input wire SFR_WE,
   input wire SFR_RE,
   input wire [7:0] SFR_WDATA,
   input wire [7:0] SFR_RDATA,
   // flash side
   input wire [21:0] TABLE_POINTER,
   input wire [7:0] TABLE_LATCH,
   input wire FLASH_ERASE_ROW,
   input wire FLASH_WRITE,
   input wire CONFIG_WRITE,
   input wire WRITE_BUSY,
   input wire WRITE_DONE_FLAG
);
// --------------------
// helper state
// --------------------
wire ctl_wr = SFR_WE && SFR_SEL == `NSW_SEL_CTRL;
wire key_wr = SFR_WE && SFR_SEL == `NSW_SEL_KEY;
wire go_try = ctl_wr && SFR_WDATA[1] && !WRITE_BUSY;
reg [31:0] busy_cnt_q;
reg write_unlock_enable_q;
reg key1_q;
reg armed_q;

// enable shadow and unlock progress; any other write breaks the unlock
always @(posedge SYS_CLK or negedge RST_B)
begin
   if (!RST_B)
   begin
      busy_cnt_q <= 32'h0;
      write_unlock_enable_q <= 1'b0;
      key1_q <= 1'b0;
      armed_q <= 1'b0;
   end
   else
   begin
      busy_cnt_q <= WRITE_BUSY ? busy_cnt_q + 32'h1 : 32'h0;
      if (WARM_RST)
         write_unlock_enable_q <= 1'b0;
      else if (ctl_wr && !WRITE_BUSY)
         write_unlock_enable_q <= SFR_WDATA[2];
      if (SFR_WE)
      begin
         key1_q <= key_wr && SFR_WDATA == `NSW_KEY1;
         armed_q <= key_wr && SFR_WDATA == `NSW_KEY2 && key1_q;
      end
   end
end
// --------------------
// assertions
// --------------------
default clocking dc @(posedge SYS_CLK); endclocking
default disable iff (!RST_B);
sequence s_unlock;
   key_wr && SFR_WDATA == `NSW_KEY1 ##1 key_wr && SFR_WDATA == `NSW_KEY2;
endsequence
sequence s_start;
   go_try && write_unlock_enable_q && !WARM_RST;
endsequence
AST_KEY_ZERO: assert property (SFR_RE && SFR_SEL == `NSW_SEL_KEY |-> SFR_RDATA == 8'h00)
   else $error("unlock port read not zero");
AST_CTRL_BITS: assert property (SFR_RE && SFR_SEL == `NSW_SEL_CTRL |->
   !SFR_RDATA[5] && !SFR_RDATA[0] && SFR_RDATA[1] == WRITE_BUSY)
   else $error("control read bits wrong");
AST_START: assert property (s_unlock ##1 s_start |=> WRITE_BUSY)
   else $error("unlocked start did not begin");
AST_NO_KEY: assert property (go_try && !armed_q |=> !WRITE_BUSY)
   else $error("start without unlock began");
AST_WRITE_UNLOCK_ENABLE_PRIOR: assert property (go_try && !write_unlock_enable_q |=> !WRITE_BUSY)
   else $error("start without prior enable began");
AST_DONE_SET: assert property ($fell(WRITE_BUSY) && !$past(WARM_RST) |-> WRITE_DONE_FLAG)
   else $error("done flag not set at completion");
AST_DONE_HOLD: assert property
   (WRITE_DONE_FLAG && !(SFR_WE && SFR_SEL == `NSW_SEL_FLAG2) |=> WRITE_DONE_FLAG)
   else $error("done flag dropped by itself");
AST_TIMER: assert property ($fell(WRITE_BUSY) && !$past(WARM_RST) |->
   busy_cnt_q >= PROG_CYCLES - 1 && busy_cnt_q <= PROG_CYCLES + 2)
   else $error("programming time wrong");
AST_ABORT: assert property (WRITE_BUSY && WARM_RST |=> !WRITE_BUSY)
   else $error("warm reset did not abort");
AST_STROBE: assert property (FLASH_WRITE || FLASH_ERASE_ROW || CONFIG_WRITE |->
   WRITE_BUSY && $onehot({FLASH_WRITE, FLASH_ERASE_ROW, CONFIG_WRITE}))
   else $error("flash strobe out of place");
AST_TP_LOW: assert property (SFR_WE && SFR_SEL == `NSW_SEL_TPL |=>
   TABLE_POINTER[7:0] == $past(SFR_WDATA))
   else $error("pointer low byte wrong");
endmodule

bind nsw_ctrl nsw_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
   .WARM_RST(WARM_RST), .SFR_SEL(SFR_SEL), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
   .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .TABLE_POINTER(TABLE_POINTER),
   .TABLE_LATCH(TABLE_LATCH), .FLASH_ERASE_ROW(FLASH_ERASE_ROW), .FLASH_WRITE(FLASH_WRITE),
   .CONFIG_WRITE(CONFIG_WRITE), .WRITE_BUSY(WRITE_BUSY), .WRITE_DONE_FLAG(WRITE_DONE_FLAG));

// [dv/nsw_ctrl_test.sv]
// nsw_ctrl_test.sv: register-level self-checking bench for the self-write unit.
// assumes: nsw_ctrl with a short programming time; checker bound alongside.
`timescale 1ns/1ps
`include "nsw_consts.vh"

module nsw_ctrl_test;
reg SYS_CLK = 1'b0;
reg RST_B = 1'b0;
reg WARM_RST = 1'b0;
reg [`NSW_SEL_W-1:0] SFR_SEL = 4'h0;
reg SFR_WE = 1'b0;
reg SFR_RE = 1'b0;
reg [7:0] SFR_WDATA = 8'h00;
wire [7:0] SFR_RDATA;
wire [21:0] TABLE_POINTER;
wire [7:0] TABLE_LATCH;
wire FLASH_ERASE_ROW, FLASH_WRITE, CONFIG_WRITE, WRITE_BUSY, WRITE_DONE_FLAG;
reg [7:0] n_fw = 8'h00;
reg [7:0] n_row = 8'h00;
reg [7:0] n_cfg = 8'h00;
wire [23:0] modes = 24'h849444;
integer miscompares = 0;
integer n_checks = 0;
integer cyc = 0;
integer k;

nsw_ctrl #(.PROG_CYCLES(8)) dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .WARM_RST(WARM_RST),
   .SFR_SEL(SFR_SEL), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_WDATA(SFR_WDATA),
   .SFR_RDATA(SFR_RDATA), .TABLE_POINTER(TABLE_POINTER), .TABLE_LATCH(TABLE_LATCH),
   .FLASH_ERASE_ROW(FLASH_ERASE_ROW), .FLASH_WRITE(FLASH_WRITE),
   .CONFIG_WRITE(CONFIG_WRITE), .WRITE_BUSY(WRITE_BUSY), .WRITE_DONE_FLAG(WRITE_DONE_FLAG));

always #50 SYS_CLK = ~SYS_CLK;

// strobe counters and hang guard; a run needs well under 1000 cycles
always @(posedge SYS_CLK)
begin
   cyc <= cyc + 1;
   n_fw <= n_fw + FLASH_WRITE;
   n_row <= n_row + FLASH_ERASE_ROW;
   n_cfg <= n_cfg + CONFIG_WRITE;
   if (cyc == 2000)
   begin
      miscompares = miscompares + 1;
      finish_test;
   end
end

task finish_test;
begin
   $display("checks %0d mismatches %0d", n_checks, miscompares);
   if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
   else
      $display("*** FAIL ***");
   $finish;
end
endtask

task chk(input logic [31:0] got, input logic [31:0] exp);
begin
   n_checks = n_checks + 1;
   if (got !== exp)
   begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
   end
end
endtask

// one register write per cycle, launched at the falling edge
task wr(input logic [3:0] s, input logic [7:0] d);
begin
   SFR_RE = 1'b0;
   SFR_WE = 1'b1;
   SFR_SEL = s;
   SFR_WDATA = d;
   @(negedge SYS_CLK);
end
endtask

task rd(input logic [3:0] s, input logic [7:0] e);
begin
   SFR_WE = 1'b0;
   SFR_RE = 1'b1;
   SFR_SEL = s;
   #1;
   chk(SFR_RDATA, e);
   @(negedge SYS_CLK);
end
endtask

task unlock(input logic [7:0] c);
begin
   wr(`NSW_SEL_CTRL, c);
   wr(`NSW_SEL_KEY, `NSW_KEY1);
   wr(`NSW_SEL_KEY, `NSW_KEY2);
   wr(`NSW_SEL_CTRL, c | 8'h02);
   chk(WRITE_BUSY, 1'b1);
end
endtask

// full write; tries to disturb the frozen registers while the timer runs
task go(input logic [7:0] c);
   integer i;
begin
   unlock(c);
   wr(`NSW_SEL_DATA, 8'h11);
   wr(`NSW_SEL_CTRL, 8'h00);
   SFR_WE = 1'b0;
   for (i = 0; i < 40 && WRITE_BUSY !== 1'b0; i = i + 1)
      @(negedge SYS_CLK);
   chk(WRITE_BUSY, 1'b0);
end
endtask

initial
begin
   repeat (16) @(negedge SYS_CLK);
   RST_B = 1'b1;
   rd(`NSW_SEL_CTRL, 8'h00);
   rd(`NSW_SEL_KEY, 8'h00);
   $display("reset test done");
   wr(`NSW_SEL_ADRH, 8'hfd);
   wr(`NSW_SEL_ADRL, 8'h23);
   wr(`NSW_SEL_DATA, 8'h5a);
   go(8'h04);
   chk(WRITE_DONE_FLAG, 1'b1);
   rd(`NSW_SEL_CTRL, 8'h04);
   rd(`NSW_SEL_FLAG2, 8'h10);
   wr(`NSW_SEL_FLAG2, 8'h00);
   rd(`NSW_SEL_FLAG2, 8'h00);
   wr(`NSW_SEL_FLAG2, 8'hff);
   rd(`NSW_SEL_FLAG2, 8'hdf);
   wr(`NSW_SEL_FLAG2, 8'h00);
   wr(`NSW_SEL_ADRH, 8'h01);
   wr(`NSW_SEL_CTRL, 8'h01);
   rd(`NSW_SEL_DATA, 8'h5a);
   rd(`NSW_SEL_CTRL, 8'h00);
   $display("array test done");
   wr(`NSW_SEL_CTRL, 8'h04);
   wr(`NSW_SEL_CTRL, 8'h06);
   rd(`NSW_SEL_CTRL, 8'h0c);
   wr(`NSW_SEL_CTRL, 8'h00);
   wr(`NSW_SEL_KEY, `NSW_KEY1);
   wr(`NSW_SEL_KEY, `NSW_KEY2);
   wr(`NSW_SEL_CTRL, 8'h06);
   rd(`NSW_SEL_CTRL, 8'h0c);
   $display("refusal test done");
   for (k = 0; k < 3; k = k + 1)
   begin
      go(modes[8*k +: 8]);
      rd(`NSW_SEL_CTRL, modes[8*k +: 8] & 8'hef);
   end
   chk({n_fw, n_row, n_cfg}, 24'h010101);
   $display("space test done");
   unlock(8'h84);
   WARM_RST = 1'b1;
   @(negedge SYS_CLK);
   WARM_RST = 1'b0;
   rd(`NSW_SEL_CTRL, 8'h88);
   wr(`NSW_SEL_ADRL, 8'h24);
   wr(`NSW_SEL_CTRL, 8'h81);
   rd(`NSW_SEL_DATA, 8'h5a);
   wr(`NSW_SEL_CTRL, 8'h40);
   wr(`NSW_SEL_CTRL, 8'h41);
   rd(`NSW_SEL_DATA, 8'h5a);
   wr(`NSW_SEL_TPL, 8'h12);
   wr(`NSW_SEL_TPH, 8'h34);
   wr(`NSW_SEL_TPU, 8'hff);
   chk(TABLE_POINTER, 22'h3f3412);
   wr(`NSW_SEL_TLAT, 8'ha5);
   chk(TABLE_LATCH, 8'ha5);
   $display("abort and pointer test done");
   finish_test;
end
endmodule

// [src/nsw_consts.vh]
// nsw_consts.vh: register selects, field positions, reset values and timing for the
// nonvolatile self-write control block.
// assumes: included by bare name from the design files; definitions only.
`ifndef NSW_CONSTS_VH
`define NSW_CONSTS_VH

// ----------------------------------------------------------------------------
// register selects on the special function register port
// ----------------------------------------------------------------------------
`define NSW_SEL_W 4
`define NSW_SEL_CTRL 4'h0
`define NSW_SEL_KEY 4'h1
`define NSW_SEL_DATA 4'h2
`define NSW_SEL_ADRL 4'h3
`define NSW_SEL_ADRH 4'h4
`define NSW_SEL_TPL 4'h5
`define NSW_SEL_TPH 4'h6
`define NSW_SEL_TPU 4'h7
`define NSW_SEL_TLAT 4'h8
`define NSW_SEL_FLAG2 4'h9
`define NSW_SEL_EN2 4'ha
`define NSW_SEL_PRI2 4'hb

// ----------------------------------------------------------------------------
// memory access control fields
// ----------------------------------------------------------------------------
`define NSW_B_PGM 7
`define NSW_B_CFG 6
`define NSW_B_UNIMP 5
`define NSW_B_ROW 4
`define NSW_B_ERR 3
`define NSW_B_WRITE_UNLOCK_ENABLE 2
`define NSW_B_WR 1
`define NSW_B_RD 0
`define NSW_B_DONE 4
`define NSW_CTRL_RST 8'h00
`define NSW_FLAG2_MASK 8'hdf

// ----------------------------------------------------------------------------
// unlock keys, address sizes and programming time
// ----------------------------------------------------------------------------
`define NSW_KEY1 8'h55
`define NSW_KEY2 8'haa
`define NSW_ADR_W 10
`define NSW_DEPTH 1024
`define NSW_PROG_TIME_US 4000
`define NSW_CLK_MHZ 10
`define NSW_PROG_CYC (`NSW_PROG_TIME_US * `NSW_CLK_MHZ)

`endif

// [src/nsw_ctrl.v]
// nsw_ctrl.v: nonvolatile self-write control unit with its register set.
// assumes: the core drives one register access per clock (an instruction cycle);
// the array is flip-flops here, flash and configuration are reached by pins.
`timescale 1ns/1ps
`include "nsw_consts.vh"

module nsw_ctrl
#(
   parameter PROG_CYCLES = `NSW_PROG_CYC,
   parameter ADR_W = `NSW_ADR_W,
   parameter DEPTH = `NSW_DEPTH
)
(
   // clock and reset
   input wire SYS_CLK,
   input wire RST_B,
   // reset seen by the core other than power-on (pin or watchdog), level
   input wire WARM_RST,
   // special function register port
   input wire [`NSW_SEL_W-1:0] SFR_SEL,
   input wire SFR_WE,
   input wire SFR_RE,
   input wire [7:0] SFR_WDATA,
   output reg [7:0] SFR_RDATA,
   // program flash and configuration port
   output wire [21:0] TABLE_POINTER,
   output wire [7:0] TABLE_LATCH,
   output reg FLASH_ERASE_ROW,
   output reg FLASH_WRITE,
   output reg CONFIG_WRITE,
   output wire WRITE_BUSY,
   output wire WRITE_DONE_FLAG
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_KEY1 = 2'b01;
   localparam ST_ARMED = 2'b10;

   // target spaces of a write cycle
   localparam TGT_ARRAY = 2'b00;
   localparam TGT_FLASH = 2'b01;
   localparam TGT_CFG = 2'b10;

   reg [1:0] key_q;
   reg pgm_q, cfg_q, row_q, err_q, write_unlock_enable_q, wr_q;
   reg [7:0] data_q, adrl_q, adrh_q, tpl_q, tph_q, tpu_q, tlat_q;
   reg [7:0] flag2_q, en2_q, pri2_q;
   reg [7:0] mem_q [0:DEPTH-1];
   reg [1:0] target_q; // 0 array, 1 flash, 2 config
   reg row_op_q;
   reg warm_q;

   wire tmr_busy;
   wire tmr_done;
   wire [ADR_W-1:0] nvm_addr;
   wire wr_ctrl;
   wire start_ok;
   wire start_req;

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   // register write hit; keeps the select compare in one place
   function sfr_hit;
      input we;
      input [`NSW_SEL_W-1:0] sel;
      input [`NSW_SEL_W-1:0] want;
      begin
         sfr_hit = we && (sel == want);
      end
   endfunction

   // space of an operation: configuration beats the program/array select
   function [1:0] space_of;
      input cfg;
      input pgm;
      begin
         if (cfg)
            space_of = TGT_CFG;
         else if (pgm)
            space_of = TGT_FLASH;
         else
            space_of = TGT_ARRAY;
      end
   endfunction

   // address pair: upper six bits of the high byte are ignored
   assign nvm_addr = {adrh_q[1:0], adrl_q};

   // table pointer built from three bytes
   assign TABLE_POINTER = {tpu_q[5:0], tph_q, tpl_q};
   assign TABLE_LATCH = tlat_q;
   assign WRITE_BUSY = wr_q;
   assign WRITE_DONE_FLAG = flag2_q[`NSW_B_DONE];

   assign wr_ctrl = sfr_hit(SFR_WE, SFR_SEL, `NSW_SEL_CTRL);
   assign start_req = wr_ctrl && SFR_WDATA[`NSW_B_WR] && !wr_q;
   // enable must already stand, and the key must be armed; a warm reset, or a
   // timer still running off an aborted cycle, refuses the start so that the
   // stale expiry cannot cut a new cycle short
   assign start_ok = start_req && write_unlock_enable_q && (key_q == ST_ARMED)
                     && !WARM_RST && !tmr_busy;

   // ----------------------------------------------------------------------
   // programming timer
   // ----------------------------------------------------------------------
   nsw_prog_timer #(.CYCLES(PROG_CYCLES)) u_tmr
   (
      .SYS_CLK(SYS_CLK),
      .RST_B(RST_B),
      .START(start_ok),
      .BUSY(tmr_busy),
      .DONE(tmr_done)
   );

   // ----------------------------------------------------------------------
   // unlock sequence tracker
   // ----------------------------------------------------------------------
   // any other register write between keys breaks the sequence
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
         key_q <= ST_IDLE;
      else if (SFR_WE)
      begin
         case (key_q)
            ST_IDLE:
               if (SFR_SEL == `NSW_SEL_KEY && SFR_WDATA == `NSW_KEY1)
                  key_q <= ST_KEY1;
            ST_KEY1:
               if (SFR_SEL == `NSW_SEL_KEY && SFR_WDATA == `NSW_KEY2)
                  key_q <= ST_ARMED;
               else if (SFR_SEL == `NSW_SEL_KEY && SFR_WDATA == `NSW_KEY1)
                  key_q <= ST_KEY1;
               else
                  key_q <= ST_IDLE;
            default:
               // one start attempt per sequence, per byte; a fresh first key
               // restarts the sequence at once
               if (SFR_SEL == `NSW_SEL_KEY && SFR_WDATA == `NSW_KEY1)
                  key_q <= ST_KEY1;
               else
                  key_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // warm reset aborts a write in progress; program and config selects keep their values, row select clears
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pgm_q <= 1'b0;
         cfg_q <= 1'b0;
         row_q <= 1'b0;
         err_q <= 1'b0;
         write_unlock_enable_q <= 1'b0;
         wr_q <= 1'b0;
         warm_q <= 1'b0;
         target_q <= 2'b00;
         row_op_q <= 1'b0;
      end
      else
      begin
         warm_q <= WARM_RST;
         if (WARM_RST)
         begin
            if (wr_q)
               err_q <= 1'b1;
            wr_q <= 1'b0;
            write_unlock_enable_q <= 1'b0;
            row_q <= 1'b0;
         end
         else if (wr_q)
         begin
            // frozen while the cycle runs; completion clears start
            if (tmr_done)
            begin
               wr_q <= 1'b0;
               err_q <= 1'b0;
               if (row_op_q)
                  row_q <= 1'b0;
            end
         end
         else if (wr_ctrl)
         begin
            pgm_q <= SFR_WDATA[`NSW_B_PGM];
            cfg_q <= SFR_WDATA[`NSW_B_CFG];
            row_q <= SFR_WDATA[`NSW_B_ROW];
            write_unlock_enable_q <= SFR_WDATA[`NSW_B_WRITE_UNLOCK_ENABLE];
            if (start_ok)
            begin
               wr_q <= 1'b1;
               row_op_q <= row_q;
               target_q <= space_of(cfg_q, pgm_q);
            end
            else if (start_req)
               err_q <= 1'b1; // improper attempt
            else
               err_q <= SFR_WDATA[`NSW_B_ERR];
         end
      end
   end

   // ----------------------------------------------------------------------
   // flash / config strobes at cycle start
   // ----------------------------------------------------------------------
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         FLASH_ERASE_ROW <= 1'b0;
         FLASH_WRITE <= 1'b0;
         CONFIG_WRITE <= 1'b0;
      end
      else
      begin
         FLASH_ERASE_ROW <= start_ok && (space_of(cfg_q, pgm_q) == TGT_FLASH) && row_q;
         FLASH_WRITE <= start_ok && (space_of(cfg_q, pgm_q) == TGT_FLASH) && !row_q;
         CONFIG_WRITE <= start_ok && (space_of(cfg_q, pgm_q) == TGT_CFG);
      end
   end

   // ----------------------------------------------------------------------
   // data, address, table and interrupt group registers
   // ----------------------------------------------------------------------
   // read-start only takes effect on the data array, and never mid-write
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         data_q <= 8'h00;
         adrl_q <= 8'h00;
         adrh_q <= 8'h00;
         tpl_q <= 8'h00;
         tph_q <= 8'h00;
         tpu_q <= 8'h00;
         tlat_q <= 8'h00;
         flag2_q <= 8'h00;
         en2_q <= 8'h00;
         pri2_q <= 8'h00;
      end
      else
      begin
         if (wr_ctrl && !wr_q && SFR_WDATA[`NSW_B_RD] && !pgm_q && !cfg_q
             && !SFR_WDATA[`NSW_B_PGM] && !SFR_WDATA[`NSW_B_CFG])
            data_q <= mem_q[nvm_addr]; // one-cycle read, held
         else if (SFR_WE && !wr_q && SFR_SEL == `NSW_SEL_DATA)
            data_q <= SFR_WDATA;
         if (SFR_WE && !wr_q && SFR_SEL == `NSW_SEL_ADRL)
            adrl_q <= SFR_WDATA;
         if (SFR_WE && !wr_q && SFR_SEL == `NSW_SEL_ADRH)
            adrh_q <= SFR_WDATA;
         if (SFR_WE && SFR_SEL == `NSW_SEL_TPL)
            tpl_q <= SFR_WDATA;
         if (SFR_WE && SFR_SEL == `NSW_SEL_TPH)
            tph_q <= SFR_WDATA;
         if (SFR_WE && SFR_SEL == `NSW_SEL_TPU)
            tpu_q <= {2'b00, SFR_WDATA[5:0]};
         if (SFR_WE && SFR_SEL == `NSW_SEL_TLAT)
            tlat_q <= SFR_WDATA;
         if (SFR_WE && SFR_SEL == `NSW_SEL_EN2)
            en2_q <= SFR_WDATA;
         if (SFR_WE && SFR_SEL == `NSW_SEL_PRI2)
            pri2_q <= SFR_WDATA;
         // set beats a simultaneous software clear
         if (SFR_WE && SFR_SEL == `NSW_SEL_FLAG2)
            flag2_q <= SFR_WDATA & `NSW_FLAG2_MASK;
         if (tmr_done && wr_q && !WARM_RST)
            flag2_q[`NSW_B_DONE] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // data array: erase-before-write folded into one timed cycle
   // ----------------------------------------------------------------------
   // no reset on the array; contents are nonvolatile in intent
   always @(posedge SYS_CLK)
   begin
      if (tmr_done && wr_q && !WARM_RST && target_q == TGT_ARRAY)
         mem_q[nvm_addr] <= data_q; // erased and programmed as one
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always @*
   begin
      SFR_RDATA = 8'h00;
      if (!SFR_RE)
         SFR_RDATA = 8'h00;
      else if (SFR_SEL == `NSW_SEL_CTRL)
         SFR_RDATA = {pgm_q, cfg_q, 1'b0, row_q, err_q, write_unlock_enable_q, wr_q, 1'b0};
      else if (SFR_SEL == `NSW_SEL_KEY)
         SFR_RDATA = 8'h00;
      else if (SFR_SEL == `NSW_SEL_DATA)
         SFR_RDATA = data_q;
      else if (SFR_SEL == `NSW_SEL_ADRL)
         SFR_RDATA = adrl_q;
      else if (SFR_SEL == `NSW_SEL_ADRH)
         SFR_RDATA = adrh_q;
      else if (SFR_SEL == `NSW_SEL_TPL)
         SFR_RDATA = tpl_q;
      else if (SFR_SEL == `NSW_SEL_TPH)
         SFR_RDATA = tph_q;
      else if (SFR_SEL == `NSW_SEL_TPU)
         SFR_RDATA = tpu_q;
      else if (SFR_SEL == `NSW_SEL_TLAT)
         SFR_RDATA = tlat_q;
      else if (SFR_SEL == `NSW_SEL_FLAG2)
         SFR_RDATA = flag2_q;
      else if (SFR_SEL == `NSW_SEL_EN2)
         SFR_RDATA = en2_q;
      else if (SFR_SEL == `NSW_SEL_PRI2)
         SFR_RDATA = pri2_q;
   end

endmodule

// [src/nsw_prog_timer.v]
// nsw_prog_timer.v: self-timed programming cycle counter.
// assumes: one clock; start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`include "nsw_consts.vh"

module nsw_prog_timer
#(
   parameter CYCLES = `NSW_PROG_CYC
)
(
   // clock and reset
   input wire SYS_CLK,
   input wire RST_B,
   // control
   input wire START,
   output wire BUSY,
   output reg DONE
);

   reg [31:0] cnt_q;
   reg run_q;

   assign BUSY = run_q;

   // count down once started; done pulses one cycle on expiry
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cnt_q <= 32'h0;
         run_q <= 1'b0;
         DONE <= 1'b0;
      end
      else
      begin
         DONE <= 1'b0;
         if (START && !run_q)
         begin
            cnt_q <= CYCLES - 1;
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            if (cnt_q == 32'h0)
            begin
               run_q <= 1'b0;
               DONE <= 1'b1;
            end
            else
               cnt_q <= cnt_q - 32'h1;
         end
      end
   end

endmodule
